// ---- rtl/ibs_bus_status.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ibs_regs.vh"
module ibs_bus_status
(
    input wire core_clk,
    input wire rst,
    input wire [`IBS_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire ev_start,
    input wire ev_stop,
    input wire ev_master_tx_begin,
    input wire ev_ack_slot_end,
    input wire ev_nack,
    input wire ev_collision,
    input wire ev_gcall_match,
    input wire ev_wide_addr_match,
    input wire ev_slave_addr_match,
    input wire ev_slave_data,
    input wire ev_rx_byte,
    input wire [7:0] rx_shift_reg,
    input wire read_not_write,
    input wire busy,
    input wire tx_taken,
    output reg [7:0] tx_holding_reg,
    output reg tx_buffer_full,
    output reg irq
);
    reg ack_result_q;
    reg master_tx_active_q;
    reg collision_flag_q;
    reg broadcast_call_seen_q;
    reg wide_address_matched_q;
    reg tx_write_collision_q;
    reg rx_overrun_q;
    reg data_not_address_q;
    reg stop_seen_q;
    reg start_seen_q;
    reg rw_q;
    reg rx_buffer_full_q;
    reg [7:0] rx_holding_reg_q;
    reg [`IBS_IRQ_W-1:0] irq_stat_q;
    reg [`IBS_IRQ_W-1:0] irq_en_q;
    reg [15:0] status_w;
    reg [15:0] rdata_d;
    reg [`IBS_IRQ_W-1:0] irq_ev;
    wire wr_clear = reg_wr && (reg_addr == `IBS_OFF_CLEAR);
    wire wr_tx = reg_wr && (reg_addr == `IBS_OFF_TXDATA);
    wire rd_rx = reg_rd && (reg_addr == `IBS_OFF_RXDATA);
    wire wr_irq_clr = reg_wr && (reg_addr == `IBS_OFF_IRQ_CLR);
    wire tx_blocked = busy || tx_buffer_full;
    wire overrun_ev = ev_rx_byte && rx_buffer_full_q && !rd_rx;
    wire condition_ev = ev_start || ev_stop;

    always @*
    begin
        status_w = `IBS_RESET_16;
        status_w[`IBS_BIT_ACK] = ack_result_q;
        status_w[`IBS_BIT_TRS] = master_tx_active_q;
        status_w[`IBS_BIT_COL] = collision_flag_q;
        status_w[`IBS_BIT_GC] = broadcast_call_seen_q;
        status_w[`IBS_BIT_A10] = wide_address_matched_q;
        status_w[`IBS_BIT_WCOL] = tx_write_collision_q;
        status_w[`IBS_BIT_OV] = rx_overrun_q;
        status_w[`IBS_BIT_DA] = data_not_address_q;
        status_w[`IBS_BIT_P] = stop_seen_q;
        status_w[`IBS_BIT_S] = start_seen_q;
        status_w[`IBS_BIT_RW] = rw_q;
        status_w[`IBS_BIT_RBF] = rx_buffer_full_q;
        status_w[`IBS_BIT_TBF] = tx_buffer_full;
    end

    always @*
    begin
        rdata_d = 16'h0000;
        case (reg_addr)
            `IBS_OFF_STATUS: rdata_d = status_w;
            `IBS_OFF_RXDATA: rdata_d = {8'h00, rx_holding_reg_q};
            `IBS_OFF_TXDATA: rdata_d = {8'h00, tx_holding_reg};
            `IBS_OFF_IRQ_STAT: rdata_d = {{(16-`IBS_IRQ_W){1'b0}}, irq_stat_q};
            `IBS_OFF_IRQ_EN: rdata_d = {{(16-`IBS_IRQ_W){1'b0}}, irq_en_q};
            default: rdata_d = 16'h0000;
        endcase
    end

    always @*
    begin
        irq_ev = {`IBS_IRQ_W{1'b0}};
        irq_ev[`IBS_IRQ_COL] = ev_collision;
        irq_ev[`IBS_IRQ_WCOL] = wr_tx && tx_blocked;
        irq_ev[`IBS_IRQ_OV] = overrun_ev;
        irq_ev[`IBS_IRQ_STOP] = ev_stop;
        irq_ev[`IBS_IRQ_ACK] = ev_ack_slot_end && master_tx_active_q;
    end

    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 16'h0000;
            ack_result_q <= 1'b0;
            master_tx_active_q <= 1'b0;
            collision_flag_q <= 1'b0;
            broadcast_call_seen_q <= 1'b0;
            wide_address_matched_q <= 1'b0;
            tx_write_collision_q <= 1'b0;
            rx_overrun_q <= 1'b0;
            data_not_address_q <= 1'b0;
            stop_seen_q <= 1'b0;
            start_seen_q <= 1'b0;
            rw_q <= 1'b0;
            rx_buffer_full_q <= 1'b0;
            rx_holding_reg_q <= 8'h00;
            tx_holding_reg <= 8'h00;
            tx_buffer_full <= 1'b0;
            irq_stat_q <= {`IBS_IRQ_W{1'b0}};
            irq_en_q <= {`IBS_IRQ_W{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            reg_rdata <= reg_rd ? rdata_d : 16'h0000;
            if (ev_ack_slot_end && master_tx_active_q)
                ack_result_q <= ev_nack; // [RULE_01]
            if (ev_master_tx_begin)
                master_tx_active_q <= 1'b1; // [RULE_02]
            else if (ev_ack_slot_end)
                master_tx_active_q <= 1'b0; // [RULE_02]
            // Hardware set wins over a software clear in the same cycle
            if (ev_collision)
                collision_flag_q <= 1'b1; // [RULE_03]
            else if (wr_clear && reg_wdata[`IBS_BIT_COL])
                collision_flag_q <= 1'b0;
            if (ev_gcall_match)
                broadcast_call_seen_q <= 1'b1; // [RULE_04]
            else if (ev_stop)
                broadcast_call_seen_q <= 1'b0; // [RULE_04]
            if (ev_wide_addr_match)
                wide_address_matched_q <= 1'b1; // [RULE_05]
            else if (ev_stop)
                wide_address_matched_q <= 1'b0; // [RULE_05]
            if (wr_tx && tx_blocked)
                tx_write_collision_q <= 1'b1; // [RULE_06]
            else if (wr_clear && reg_wdata[`IBS_BIT_WCOL])
                tx_write_collision_q <= 1'b0;
            if (overrun_ev)
                rx_overrun_q <= 1'b1; // [RULE_07]
            else if (wr_clear && reg_wdata[`IBS_BIT_OV])
                rx_overrun_q <= 1'b0;
            if (ev_slave_addr_match)
            begin
                data_not_address_q <= 1'b0; // [RULE_08]
                rw_q <= read_not_write;
            end
            else if (ev_slave_data)
                data_not_address_q <= 1'b1; // [RULE_08]
            if (condition_ev)
            begin
                stop_seen_q <= ev_stop; // [RULE_09]
                start_seen_q <= !ev_stop; // [RULE_10]
            end
            // An overrun keeps the older byte in the holding register
            if (ev_rx_byte && !overrun_ev)
            begin
                rx_holding_reg_q <= rx_shift_reg;
                rx_buffer_full_q <= 1'b1; // [RULE_11]
            end
            else if (rd_rx)
                rx_buffer_full_q <= 1'b0; // [RULE_11]
            if (wr_tx && !tx_blocked)
            begin
                tx_holding_reg <= reg_wdata[7:0]; // [RULE_06]
                tx_buffer_full <= 1'b1; // [RULE_11]
            end
            else if (tx_taken)
                tx_buffer_full <= 1'b0; // [RULE_11]
            irq_stat_q <= (irq_stat_q & ~(wr_irq_clr ? reg_wdata[`IBS_IRQ_W-1:0] : {`IBS_IRQ_W{1'b0}})) | irq_ev;
            if (reg_wr && (reg_addr == `IBS_OFF_IRQ_EN))
                irq_en_q <= reg_wdata[`IBS_IRQ_W-1:0];
            irq <= |(irq_stat_q & irq_en_q);
        end
    end
endmodule
`default_nettype wire

// ---- rtl/ibs_regs.vh ----
// What this block does
// [RULE_01] In a master transmit, the acknowledge result bit takes 1 on NACK and 0 on ACK at the end of the acknowledge slot.
// [RULE_02] The master transmit active bit is set when a master transmission starts and cleared at the end of the acknowledge.
// [RULE_03] A bus collision during a master operation sets the collision flag, which stays until software clears it.
// [RULE_04] A received general call address sets the broadcast call bit, and a Stop clears it.
// [RULE_05] A match of the second byte of a 10-bit address sets the wide address bit, and a Stop clears it.
// [RULE_06] A write to the transmit holding register while busy is dropped and sets the write collision flag, which only software clears.
// [RULE_07] A received byte that finds the receive holding register still full sets the overrun flag, which only software clears.
// [RULE_08] In slave operation the data/address bit clears on an address match and sets on a received data byte.
// [RULE_09] On each Start, Repeated Start or Stop the stop seen bit takes 1 for a Stop and 0 otherwise.
// [RULE_10] The start seen bit is the complement of the stop seen bit, updated on the same conditions; reset clears both bits to 0.
// [RULE_11] The receive and transmit buffer full bits show an unread received byte and an unsent transmit byte.
`ifndef IBS_REGS_VH
`define IBS_REGS_VH
`define IBS_ADDR_W 4
`define IBS_OFF_STATUS 4'h0
`define IBS_OFF_CLEAR 4'h1
`define IBS_OFF_TXDATA 4'h2
`define IBS_OFF_RXDATA 4'h3
`define IBS_OFF_IRQ_STAT 4'h4
`define IBS_OFF_IRQ_CLR 4'h5
`define IBS_OFF_IRQ_EN 4'h6
`define IBS_OFF_CTRL 4'h7
`define IBS_BIT_ACK 15
`define IBS_BIT_TRS 14
`define IBS_BIT_COL 10
`define IBS_BIT_GC 9
`define IBS_BIT_A10 8
`define IBS_BIT_WCOL 7
`define IBS_BIT_OV 6
`define IBS_BIT_DA 5
`define IBS_BIT_P 4
`define IBS_BIT_S 3
`define IBS_BIT_RW 2
`define IBS_BIT_RBF 1
`define IBS_BIT_TBF 0
`define IBS_IRQ_COL 0
`define IBS_IRQ_WCOL 1
`define IBS_IRQ_OV 2
`define IBS_IRQ_STOP 3
`define IBS_IRQ_ACK 4
`define IBS_IRQ_W 5
`define IBS_RESET_16 16'h0000
`endif

// ---- sim/ibs_bus_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module ibs_bus_partner (
    input wire logic core_clk,
    output logic [10:0] ev,
    output logic nack
);
    initial
    begin
        ev = 11'h000;
        nack = 1'b1;
    end
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge core_clk);
        ev <= 11'h000;
    endtask
    // Eight data bits, then the slave answer; the released line shows the inverse
    task automatic byte_out(input logic nk);
        pulse(2);
        repeat (7) @(posedge core_clk);
        nack <= nk;
        pulse(3);
        nack <= ~nk;
    endtask
endmodule
`default_nettype wire

// ---- sim/ibs_bus_status_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ibs_bus_status_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic busy,
    input wire logic tx_buffer_full,
    input wire logic [7:0] tx_holding_reg,
    input wire logic ev_master_tx_begin,
    input wire logic ev_ack_slot_end,
    input wire logic ev_nack,
    input wire logic ev_start,
    input wire logic ev_stop
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Status read with no Start, Stop or acknowledge slot end event landing in the same cycle
    wire logic rd_st = reg_rd && reg_addr == 4'h0 && !(ev_start || ev_stop || ev_ack_slot_end);
    wire logic tx_wr = reg_wr && reg_addr == 4'h2;
    sequence s_nack_byte;
        ev_master_tx_begin ##1 !ev_ack_slot_end [*7] ##1 (ev_ack_slot_end && ev_nack) ##1 rd_st;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("read data not idle");
    a_reserved_zero: assert property (reg_rd && reg_addr == 4'h7 |=> reg_rdata == 16'h0000) else $error("reserved");
    a_tx_load: assert property (tx_wr && !busy && !tx_buffer_full |=>
        tx_buffer_full && tx_holding_reg == $past(reg_wdata[7:0])) else $error("tx byte not loaded");
    a_tx_drop: assert property (tx_wr && (busy || tx_buffer_full) |=> $stable(tx_holding_reg))
        else $error("tx byte overwritten");
    a_tx_active: assert property (ev_master_tx_begin && !ev_ack_slot_end ##1 rd_st |=> reg_rdata[14])
        else $error("tx active not set");
    a_ack_nack: assert property (s_nack_byte |=> reg_rdata[15] && !reg_rdata[14])
        else $error("nack result wrong");
    a_stop_seen: assert property (ev_stop ##1 rd_st |=> reg_rdata[4] && !reg_rdata[3])
        else $error("stop flag wrong");
    a_start_seen: assert property (ev_start && !ev_stop ##1 rd_st |=> reg_rdata[3] && !reg_rdata[4])
        else $error("start flag wrong");
endmodule
bind ibs_bus_status ibs_bus_status_checker i_ibs_bus_status_checker (.*);
`default_nettype wire

// ---- sim/ibs_bus_status_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ibs_bus_status_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic busy = 1'b0;
    logic [7:0] rx_byte = 8'h00;
    logic [15:0] reg_rdata, got;
    logic [10:0] ev;
    logic nack, tx_buffer_full, irq;
    logic [7:0] tx_holding_reg, dat;
    int seed = 32;
    int n_mismatch = 0;
    int compares = 0;
    always #5 core_clk = ~core_clk;
    ibs_bus_partner i_ibs_bus_partner (.core_clk(core_clk), .ev(ev), .nack(nack));
    ibs_bus_status i_ibs_bus_status (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_start(ev[0]), .ev_stop(ev[1]),
        .ev_master_tx_begin(ev[2]), .ev_ack_slot_end(ev[3]), .ev_nack(nack), .ev_collision(ev[4]),
        .ev_gcall_match(ev[5]), .ev_wide_addr_match(ev[6]), .ev_slave_addr_match(ev[7]), .ev_slave_data(ev[8]),
        .ev_rx_byte(ev[9]), .rx_shift_reg(rx_byte), .read_not_write(nack), .busy(busy), .tx_taken(ev[10]),
        .tx_holding_reg(tx_holding_reg), .tx_buffer_full(tx_buffer_full), .irq(irq));
    function automatic logic [15:0] b(input int i);
        return 16'h0001 << i;
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic ev1(input int k);
        i_ibs_bus_partner.pulse(k);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
        chk("register read", got & m, exp);
        @(posedge core_clk);
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rdc(4'h0, 16'hffff, 16'h0000);
        rdc(4'h7, 16'hffff, 16'h0000);
        ev1(0);
        rdc(4'h0, b(4) | b(3), b(3));
        ev1(1);
        rdc(4'h0, b(4) | b(3), b(4));
        for (int k = 1; k >= 0; k--)
        begin
            i_ibs_bus_partner.byte_out(k[0]);
            rdc(4'h0, b(15) | b(14), k ? b(15) : 16'h0000);
        end
        ev1(2);
        rdc(4'h0, b(14), b(14));
        $display("conditions and master byte done");
        ev1(4);
        rdc(4'h0, b(10), b(10));
        chk("irq masked", {15'h0000, irq}, 16'h0000);
        rdc(4'h4, b(0), b(0));
        wr(4'h6, 16'h0001);
        rdc(4'h6, 16'hffff, 16'h0001);
        chk("irq raised", {15'h0000, irq}, 16'h0001);
        wr(4'h5, 16'h0001);
        rdc(4'h0, b(10), b(10));
        chk("irq cleared", {15'h0000, irq}, 16'h0000);
        wr(4'h1, b(10));
        rdc(4'h0, b(10), 16'h0000);
        ev1(5);
        rdc(4'h0, b(9) | b(8), b(9));
        ev1(6);
        rdc(4'h0, b(9) | b(8), b(9) | b(8));
        ev1(1);
        rdc(4'h0, b(9) | b(8), 16'h0000);
        ev1(8);
        rdc(4'h0, b(5), b(5));
        ev1(7);
        rdc(4'h0, b(5) | b(2), b(2));
        $display("flags and irq done");
        dat = 8'($random(seed));
        wr(4'h2, {8'h00, dat});
        wr(4'h2, {8'h00, ~dat});
        rdc(4'h0, b(7) | b(0), b(7) | b(0));
        chk("tx holding", {8'h00, tx_holding_reg}, {8'h00, dat});
        wr(4'h1, b(7));
        ev1(10);
        busy <= 1'b1;
        wr(4'h2, {8'h00, dat});
        busy <= 1'b0;
        rdc(4'h0, b(7) | b(0), b(7));
        repeat (3)
        begin
            dat = 8'($random(seed));
            rx_byte <= dat;
            ev1(9);
            rdc(4'h0, b(6) | b(1), b(1));
            rdc(4'h3, 16'hffff, {8'h00, dat});
            rx_byte <= ~dat;
            ev1(9);
            @(posedge core_clk);
            ev1(9);
            rdc(4'h0, b(6) | b(1), b(6) | b(1));
            rdc(4'h3, 16'hffff, {8'h00, ~dat});
            wr(4'h1, b(6));
            rdc(4'h0, b(6) | b(1), 16'h0000);
        end
        $display("tx and rx buffers done");
        final_report();
    end
endmodule
`default_nettype wire
